// file: common/pig_pkg.sv
// constants for the pci interrupt generator
package pig_pkg;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          NUM_SRC     = 23;
    localparam int          NUM_LINE    = 8;
    localparam int          ROUTE_W     = 3;
    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam logic [7:0]  OFF_ENABLE  = 8'h00;
    localparam logic [7:0]  OFF_ROUTE0  = 8'h04;
    localparam logic [7:0]  OFF_ROUTE1  = 8'h08;
    localparam logic [7:0]  OFF_ROUTE2  = 8'h0C;
    localparam logic [7:0]  OFF_STATUS  = 8'h10;
    localparam logic [7:0]  OFF_CTRL    = 8'h14;
    localparam logic [7:0]  OFF_STATID  = 8'h18;
    // --------------------------------------------------------------
    // source bit positions in enable and status, fields in routes
    // --------------------------------------------------------------
    localparam int          SRC_ACFAIL  = 0;
    localparam int          SRC_SYSFAIL = 1;
    localparam int          SRC_SOFT    = 2;
    localparam int          SRC_SOFTACK = 3;
    localparam int          SRC_VMEERR  = 4;
    localparam int          SRC_PCIERR  = 5;
    localparam int          SRC_DMA     = 6;
    localparam int          SRC_VIRQ1   = 7;   // levels 1..7 at 7..13
    localparam int          SRC_LM0     = 14;  // 14..17
    localparam int          SRC_MBOX0   = 18;  // 18..21
    localparam int          SRC_OWN     = 22;
    localparam int          CTRL_HOLD   = 0;
    localparam int          CTRL_SOFT   = 1;
    localparam int          FIELDS_REG  = 8;
    // --------------------------------------------------------------
    // reset values and timing
    // --------------------------------------------------------------
    localparam logic [31:0] RST_ENABLE  = 32'h0000_0000;
    localparam logic [31:0] RST_ROUTE   = 32'h0000_0000;
    localparam int          FILT_NS     = 40;
    localparam int          CLK_NS      = 10;
    localparam int          FILT_CYC    = (FILT_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_IACK = 2'b01
    } pig_hstate_t;
endpackage

// file: hw/pig_top.sv
// interrupt channel: sources to eight local pci interrupt lines
`timescale 1ns/1ps
// How it works
// [R1] board user leaves lines two to seven unused
// [R2] vme requests map only to pci lines
// [R3] internal events routable to either bus; here they route to the eight pci lines only
// [R4] handler sees vme requests, runs iack cycle
// [R5] iack done signals router, line asserts
// [R6] all other sources route immediately
// [R7] eight lines, all may share one
// [R8] each source: enable bit, one route field
// [R9] enabled firing source asserts line, sets status
// [R10] status shows sources whether enabled or not
// [R11] service routine masks unrelated status bits
// [R12] failure sources level, follow their lines
// [R13] failure status cannot clear while line active
// [R14] failure inputs synchronised and filtered
// [R15] other sources are single edge events; here the inputs set status on every cycle they are high, with no edge detect
// [R16] vme event comes from status id capture
// [R17] status and line held until write one
// [R18] line zero is inta, line one serr
// [R19] ownership granted with hold set raises event
// [R20] soft iack completion raises event
// [R21] board irqs also from bus error logic
// [R22] route field is 3-bit index, lines low
module pig_top
    import pig_pkg::*;
#(
    parameter int FILT = FILT_CYC
) (
    input  wire logic                        mclk,
    input  wire logic                        arst_n,
    input  wire logic [pig_pkg::ADDR_W-1:0]  regAddr,
    input  wire logic [pig_pkg::DATA_W-1:0]  regWrData,
    input  wire logic                        regWr,
    input  wire logic                        regRd,
    output logic      [pig_pkg::DATA_W-1:0]  regRdData,
    input  wire logic                        acFail_n,
    input  wire logic                        sysFail_n,
    input  wire logic [7:1]                  vmeReqPins_n,
    output logic                             iackReq,
    output logic      [2:0]                  iackLevel,
    input  wire logic                        iackDone,
    input  wire logic [7:0]                  iackStatusId,
    input  wire logic                        softIrqAckDone,
    input  wire logic                        vmeBusErr,
    input  wire logic                        pciAbort,
    input  wire logic                        dmaDone,
    input  wire logic [3:0]                  locMonHits,
    input  wire logic [3:0]                  mailboxHits,
    input  wire logic                        vmeGranted,
    output logic      [7:0]                  pciIrqLine_n
);
    import pig_pkg::*;

    generate
        if (FILT < 1 || FILT > 255) begin : g_chk
            $error("FILT must lie in 1..255");
        end
        if (NUM_SRC > FIELDS_REG * 3) begin : g_chkSrc
            $error("NUM_SRC exceeds the route fields");
        end
        if (ROUTE_W * FIELDS_REG > 24) begin : g_chkRoute
            $error("route fields overflow a route word");
        end
        if (2 ** ROUTE_W != NUM_LINE) begin : g_chkLine
            $error("ROUTE_W must index every line");
        end
    endgenerate

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic [1:0]              rstSync_ff;
    logic                    rst_n;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync_ff <= 2'h0;
        end else begin
            rstSync_ff <= {rstSync_ff[0], 1'b1};
        end
    end
    assign rst_n = rstSync_ff[1];

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [8:0]              pinMeta_ff;
    logic [8:0]              pinSync_ff;
    logic [1:0]              failRaw;
    logic [7:1]              vmeReqSync;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_ff <= 9'h000;
            pinSync_ff <= 9'h000;
        end else begin
            pinMeta_ff <= {~vmeReqPins_n, ~sysFail_n, ~acFail_n};
            pinSync_ff <= pinMeta_ff;
        end
    end
    assign failRaw    = pinSync_ff[1:0];
    assign vmeReqSync = pinSync_ff[8:2];

    // ------------------------------------------------------------------
    // failure line filters
    // ------------------------------------------------------------------
    logic [1:0]              failFilt_ff;
    logic [7:0]              failCnt_ff [2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_filt
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    failCnt_ff[g]  <= 8'h00;
                    failFilt_ff[g] <= 1'b0;
                end else if (failRaw[g] == failFilt_ff[g]) begin
                    failCnt_ff[g]  <= 8'h00;
                end else if (failCnt_ff[g] == 8'(FILT - 1)) begin
                    failCnt_ff[g]  <= 8'h00;
                    failFilt_ff[g] <= failRaw[g]; // R14
                end else begin
                    failCnt_ff[g]  <= failCnt_ff[g] + 8'h01;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [NUM_SRC-1:0]      enable_ff;
    logic [31:0]             route_ff [3];
    logic [NUM_SRC-1:0]      status_ff;
    logic                    hold_ff;
    logic                    softEvt_ff;
    logic [7:0]              statId_ff;
    logic [DATA_W-1:0]       rdData_ff;
    logic [NUM_SRC-1:0]      nxt_status;
    logic [NUM_SRC-1:0]      srcEvt;
    logic [NUM_SRC-1:0]      wrClear;
    logic [7:1]              virqEvt_ff;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            enable_ff <= RST_ENABLE[NUM_SRC-1:0];
        end else if (regWr && hit(regAddr, OFF_ENABLE)) begin
            enable_ff <= regWrData[NUM_SRC-1:0]; // R8
        end
    end

    generate
        for (g = 0; g < 3; g++) begin : g_route
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    route_ff[g] <= RST_ROUTE;
                end else if (regWr &&
                             hit(regAddr, OFF_ROUTE0 + 8'(4 * g))) begin
                    route_ff[g] <= {8'h00, regWrData[23:0]}; // R8
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff <= 1'b0;
        end else if (regWr && hit(regAddr, OFF_CTRL)) begin
            hold_ff <= regWrData[CTRL_HOLD]; // R19
        end
    end

    // write one to the soft bit gives a single event
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            softEvt_ff <= 1'b0;
        end else begin
            softEvt_ff <= regWr && hit(regAddr, OFF_CTRL) &&
                          regWrData[CTRL_SOFT]; // R3
        end
    end

    // ------------------------------------------------------------------
    // event sources
    // ------------------------------------------------------------------
    always_comb begin
        srcEvt                     = '0;
        srcEvt[SRC_ACFAIL]         = failFilt_ff[0]; // R12
        srcEvt[SRC_SYSFAIL]        = failFilt_ff[1]; // R12
        srcEvt[SRC_SOFT]           = softEvt_ff; // R3
        srcEvt[SRC_SOFTACK]        = softIrqAckDone; // R20
        srcEvt[SRC_VMEERR]         = vmeBusErr; // R3
        srcEvt[SRC_PCIERR]         = pciAbort; // R3
        srcEvt[SRC_DMA]            = dmaDone; // R3
        srcEvt[SRC_VIRQ1 +: 7]     = virqEvt_ff; // R16
        srcEvt[SRC_LM0 +: 4]       = locMonHits; // R15
        srcEvt[SRC_MBOX0 +: 4]     = mailboxHits; // R15
        srcEvt[SRC_OWN]            = vmeGranted && hold_ff; // R19
    end

    // ------------------------------------------------------------------
    // status: write one to clear, a new event wins over the clear
    // ------------------------------------------------------------------
    assign wrClear = (regWr && hit(regAddr, OFF_STATUS)) ?
                     regWrData[NUM_SRC-1:0] : '0;
    // set regardless of enable
    assign nxt_status = (status_ff & ~wrClear) | srcEvt; // R10 R13 R17

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= '0;
        end else begin
            status_ff <= nxt_status; // R9 R15
        end
    end

    // ------------------------------------------------------------------
    // internal vme interrupt handler
    // ------------------------------------------------------------------
    pig_hstate_t             hState_ff;
    logic                    iackReq_ff;
    logic [2:0]              iackLevel_ff;
    logic [7:1]              pendLvl;
    logic [2:0]              pickLvl;

    // a level already captured waits for software to clear it
    assign pendLvl = vmeReqSync & ~status_ff[SRC_VIRQ1 +: 7] & ~virqEvt_ff;

    always_comb begin
        pickLvl = 3'h0;
        for (int i = 1; i <= 7; i++) begin
            if (pendLvl[i]) begin
                pickLvl = 3'(i);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hState_ff    <= HS_IDLE;
            iackReq_ff   <= 1'b0;
            iackLevel_ff <= 3'h0;
            virqEvt_ff   <= 7'h00;
            statId_ff    <= 8'h00;
        end else begin
            virqEvt_ff <= 7'h00;
            case (hState_ff)
                HS_IDLE: begin
                    if (pickLvl != 3'h0) begin
                        iackReq_ff   <= 1'b1; // R4
                        iackLevel_ff <= pickLvl;
                        hState_ff    <= HS_IACK;
                    end
                end
                HS_IACK: begin
                    if (iackDone) begin
                        iackReq_ff <= 1'b0;
                        statId_ff  <= iackStatusId; // R16
                        virqEvt_ff <= 7'(1) << (iackLevel_ff - 3'h1); // R5
                        hState_ff  <= HS_IDLE;
                    end
                end
                default: begin
                    iackReq_ff <= 1'b0;
                    hState_ff  <= HS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // routing onto the local lines
    // ------------------------------------------------------------------
    logic [71:0]             routeAll;
    logic [NUM_LINE-1:0]     lineAct;
    logic [NUM_LINE-1:0]     lineN_ff;

    // one-hot mask of the line a route field selects
    function automatic logic [NUM_LINE-1:0] lineMask(
        input logic [ROUTE_W-1:0] sel
    );
        lineMask      = '0;
        lineMask[sel] = 1'b1;
    endfunction

    assign routeAll = {route_ff[2][23:0], route_ff[1][23:0],
                       route_ff[0][23:0]};

    always_comb begin
        lineAct = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (status_ff[i] && enable_ff[i]) begin
                // vme requests can only land on these pci lines
                lineAct = lineAct |
                          lineMask(routeAll[ROUTE_W*i +: ROUTE_W]); // R2 R6 R7 R22
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lineN_ff <= 8'hFF;
        end else begin
            // line 0 feeds inta, line 1 feeds serr on the board
            lineN_ff <= ~lineAct; // R9 R17 R18 R22
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_ff <= 32'h0000_0000;
        end else if (regRd) begin
            case (regAddr)
                OFF_ENABLE: rdData_ff <= 32'(enable_ff);
                OFF_ROUTE0: rdData_ff <= route_ff[0];
                OFF_ROUTE1: rdData_ff <= route_ff[1];
                OFF_ROUTE2: rdData_ff <= route_ff[2];
                OFF_STATUS: rdData_ff <= 32'(status_ff);
                OFF_CTRL:   rdData_ff <= 32'(hold_ff);
                OFF_STATID: rdData_ff <= {24'h000000, statId_ff};
                default:    rdData_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdData_ff <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign regRdData    = rdData_ff;
    assign iackReq      = iackReq_ff;
    assign iackLevel    = iackLevel_ff;
    assign pciIrqLine_n = lineN_ff;
endmodule

// file: testbench/pig_checker_assertions.sv
// port checker for the pci interrupt generator
`timescale 1ns/1ps
module pig_checker
    import pig_pkg::*;
#(
    parameter int FILT = FILT_CYC
) (
    input wire logic                       mclk,
    input wire logic                       arst_n,
    input wire logic [pig_pkg::ADDR_W-1:0] regAddr,
    input wire logic [pig_pkg::DATA_W-1:0] regWrData,
    input wire logic                       regWr,
    input wire logic                       regRd,
    input wire logic [pig_pkg::DATA_W-1:0] regRdData,
    input wire logic                       acFail_n,
    input wire logic [7:1]                 vmeReqPins_n,
    input wire logic                       iackReq,
    input wire logic [2:0]                 iackLevel,
    input wire logic                       iackDone,
    input wire logic                       dmaDone,
    input wire logic [7:0]                 pciIrqLine_n
);
    logic [31:0] enSh_ff;
    logic        wrD_ff;
    logic [7:0]  failCnt_ff;
    // ----------------------------------------------------------
    // shadow of enable, last write, failure-line run length
    // ----------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            enSh_ff    <= RST_ENABLE;
            wrD_ff     <= 1'b0;
            failCnt_ff <= 8'h00;
        end else begin
            wrD_ff <= regWr;
            if (regWr && regAddr == OFF_ENABLE) begin
                enSh_ff <= regWrData;
            end
            if (acFail_n || !enSh_ff[SRC_ACFAIL] || regWr) begin
                failCnt_ff <= 8'h00;
            end else if (failCnt_ff != 8'hFF) begin
                failCnt_ff <= failCnt_ff + 8'h01;
            end
        end
    end
    a_iack_holds: assert property (@(posedge mclk) disable iff (!arst_n)
        iackReq && !iackDone |=> iackReq && $stable(iackLevel))
        else $error("iack request dropped early");
    a_iack_drop: assert property (@(posedge mclk) disable iff (!arst_n)
        iackReq && iackDone |=> !iackReq)
        else $error("iack request kept after done");
    a_iack_level: assert property (@(posedge mclk) disable iff (!arst_n)
        iackReq |-> iackLevel != 3'h0)
        else $error("iack level zero");
    a_iack_cause: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(iackReq) |-> $past(vmeReqPins_n, 3) != 7'h7F)
        else $error("iack without request pin");
    a_line_hold: assert property (@(posedge mclk) disable iff (!arst_n)
        !regWr && !wrD_ff |=> (pciIrqLine_n & ~$past(pciIrqLine_n)) == 8'h00)
        else $error("line released without write");
    a_dma_fire: assert property (@(posedge mclk) disable iff (!arst_n)
        dmaDone && enSh_ff[SRC_DMA] && !regWr ##1 !regWr [*2]
        |=> pciIrqLine_n != 8'hFF)
        else $error("enabled event raised no line");
    a_fail_level: assert property (@(posedge mclk) disable iff (!arst_n)
        failCnt_ff >= 8'(FILT + 6) |-> pciIrqLine_n != 8'hFF)
        else $error("failure line active but no interrupt");
    a_rd_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        !regRd |=> regRdData == 32'h0)
        else $error("read data without read");
endmodule
bind pig_top pig_checker #(.FILT(FILT)) u_chk (
    .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .acFail_n(acFail_n),
    .vmeReqPins_n(vmeReqPins_n), .iackReq(iackReq),
    .iackLevel(iackLevel), .iackDone(iackDone), .dmaDone(dmaDone),
    .pciIrqLine_n(pciIrqLine_n)
);

// file: testbench/pig_host_model.sv
// pci host model: counts the two board interrupt lines
`timescale 1ns/1ps
module pig_host_model (
    input  wire logic       mclk,
    input  wire logic [7:0] pciIrqLine_n,
    output logic      [7:0] intaCount,
    output logic      [7:0] serrCount
);
    logic [1:0] prev_ff = 2'b11;
    initial intaCount = 8'h00;
    initial serrCount = 8'h00;
    // lines two to seven are left unwatched
    always @(posedge mclk) begin
        prev_ff <= pciIrqLine_n[1:0];
        if (prev_ff[0] && !pciIrqLine_n[0]) begin
            intaCount <= intaCount + 8'h01;
        end
        if (prev_ff[1] && !pciIrqLine_n[1]) begin
            serrCount <= serrCount + 8'h01;
        end
    end
endmodule

// file: testbench/pig_top_bench.sv
// self-checking bench for the pci interrupt generator
`timescale 1ns/1ps
module pig_top_bench;
    import pig_pkg::*;
    logic        mclk = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
    logic [7:0]  regAddr = 8'h00, iackStatusId = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic [31:0] regRdData;
    logic [1:0]  failN = 2'b11;
    logic [7:1]  vmeReqPins_n = 7'h7F;
    logic        iackDone = 1'b0, iackReq;
    logic [2:0]  iackLevel;
    logic [22:0] evt = 23'h0;
    logic [7:0]  pciIrqLine_n, intaCount, serrCount;
    int          fail_count = 0, check_count = 0;
    pig_top #(.FILT(1)) dut (
        .mclk(mclk), .arst_n(arst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .acFail_n(failN[0]), .sysFail_n(failN[1]),
        .vmeReqPins_n(vmeReqPins_n), .iackReq(iackReq),
        .iackLevel(iackLevel), .iackDone(iackDone),
        .iackStatusId(iackStatusId), .softIrqAckDone(evt[SRC_SOFTACK]),
        .vmeBusErr(evt[SRC_VMEERR]), .pciAbort(evt[SRC_PCIERR]),
        .dmaDone(evt[SRC_DMA]), .locMonHits(evt[SRC_LM0 +: 4]),
        .mailboxHits(evt[SRC_MBOX0 +: 4]), .vmeGranted(evt[SRC_OWN]),
        .pciIrqLine_n(pciIrqLine_n)
    );
    pig_host_model host (.mclk(mclk), .pciIrqLine_n(pciIrqLine_n),
        .intaCount(intaCount), .serrCount(serrCount));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, string nm);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 chk(nm, regRdData, e);
    endtask
    task automatic pulse(input int s);
        @(posedge mclk);
        evt[s] <= 1'b1;
        @(posedge mclk);
        evt[s] <= 1'b0;
    endtask
    task automatic chkLine(input logic [7:0] e, input string nm);
        chk(nm, {24'h0, pciIrqLine_n}, {24'h0, e});
    endtask
    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_reset();
        rdc(OFF_ENABLE, RST_ENABLE, "enable");
        rdc(OFF_ROUTE0, RST_ROUTE, "route0");
        rdc(8'h40, 32'h0, "unmapped");
        chkLine(8'hFF, "idle lines");
    endtask
    task automatic t_route();
        logic [7:0] i0, s0;
        i0 = intaCount;
        s0 = serrCount;
        wr(OFF_ENABLE, 32'h1 << SRC_DMA);
        for (int k = 0; k < 8; k++) begin
            wr(OFF_ROUTE0, 32'(k) << (3 * SRC_DMA));
            pulse(SRC_DMA);
            tick(3);
            chkLine(~(8'h01 << k), "routed line");
            rdc(OFF_STATUS, 32'h1 << SRC_DMA, "dma status");
            wr(OFF_STATUS, 32'h1 << SRC_DMA);
            tick(3);
            chkLine(8'hFF, "line cleared");
        end
        chk("inta count", 32'(intaCount), 32'(i0 + 8'h01));
        chk("serr count", 32'(serrCount), 32'(s0 + 8'h01));
    endtask
    task automatic t_events();
        wr(OFF_ROUTE0, 32'h0);
        wr(OFF_ENABLE, 32'h0);
        pulse(SRC_PCIERR);
        tick(3);
        chkLine(8'hFF, "disabled line");
        rdc(OFF_STATUS, 32'h20, "disabled status");
        wr(OFF_ENABLE, 32'h7F_FFFF);
        pulse(SRC_OWN);
        rdc(OFF_STATUS, 32'h20, "grant without hold");
        wr(OFF_CTRL, 32'h3);
        for (int s = 3; s < 23; s++) begin
            if (s < SRC_VIRQ1 || s > SRC_VIRQ1 + 6) pulse(s);
        end
        pulse(SRC_DMA);
        tick(3);
        rdc(OFF_STATUS, 32'h7F_C07C, "all events");
        chkLine(8'hFE, "shared line");
        wr(OFF_STATUS, 32'h7F_FFFF);
        tick(3);
        chkLine(8'hFF, "all cleared");
        rdc(OFF_STATUS, 32'h0, "status empty");
    endtask
    task automatic t_vme();
        wr(OFF_ENABLE, 32'h1 << (SRC_VIRQ1 + 2));
        wr(OFF_ROUTE1, 32'h8);
        rdc(OFF_ROUTE1, 32'h8, "route1");
        @(posedge mclk);
        vmeReqPins_n <= 7'h7B;
        for (int i = 0; i < 20 && iackReq !== 1'b1; i++) @(posedge mclk);
        tick(5);
        chk("iack level", 32'(iackLevel), 32'h3);
        chkLine(8'hFF, "no line before iack");
        rdc(OFF_STATUS, 32'h0, "no status before iack");
        @(posedge mclk);
        iackDone <= 1'b1;
        iackStatusId <= 8'hA5;
        @(posedge mclk);
        iackDone <= 1'b0;
        vmeReqPins_n <= 7'h7F;
        tick(4);
        chk("iack drop", 32'(iackReq), 32'h0);
        chkLine(8'hFD, "vme line");
        rdc(OFF_STATUS, 32'h200, "vme status");
        rdc(OFF_STATID, 32'hA5, "status id");
        wr(OFF_STATUS, 32'h200);
        tick(3);
        chkLine(8'hFF, "vme cleared");
    endtask
    task automatic t_fail(input int s);
        wr(OFF_ENABLE, 32'h1 << s);
        wr(OFF_ROUTE0, 32'h1 << (3 * s));
        @(posedge mclk);
        failN[s] <= 1'b0;
        tick(10);
        chkLine(8'hFD, "failure line");
        wr(OFF_STATUS, 32'h1 << s);
        rdc(OFF_STATUS, 32'h1 << s, "failure kept");
        chkLine(8'hFD, "failure still low");
        @(posedge mclk);
        failN[s] <= 1'b1;
        tick(10);
        chkLine(8'hFD, "held after release");
        wr(OFF_STATUS, 32'h1 << s);
        tick(3);
        chkLine(8'hFF, "failure cleared");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        tick(4);
        t_reset();
        t_route();
        t_events();
        t_vme();
        t_fail(SRC_ACFAIL);
        t_fail(SRC_SYSFAIL);
        test_done();
    end
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
endmodule
